// ==== lpb_pkg.sv ====
// Shared constants and carrier types for the link packet buffer.
// Assumes a single 50 MHz core clock and an APB register master.
package lpb_pkg;

  // ----------------------------------------------------------------
  // Stream layout
  // ----------------------------------------------------------------
  localparam int         LPB_ACK_W    = 6;
  localparam int         LPB_MAX_BEAT = 36;
  localparam logic [7:0] LPB_KEEP_ALL = 8'hff;
  localparam int         LPB_TU_RESP  = 4;
  localparam int         LPB_TU_SOP   = 3;
  localparam int         LPB_TU_CRF   = 1;
  localparam int         LPB_TU_DISC  = 0;

  // ----------------------------------------------------------------
  // Register map and reset values
  // ----------------------------------------------------------------
  localparam logic [11:0] LPB_REG_CTRL   = 12'h000;
  localparam logic [11:0] LPB_REG_STATUS = 12'h004;
  localparam logic [11:0] LPB_REG_DROPS  = 12'h008;
  localparam int          LPB_CTRL_CRF   = 0;
  localparam int          LPB_CTRL_PAUSE = 1;
  localparam logic [1:0]  LPB_CTRL_RST   = 2'h1;
  localparam logic [5:0]  LPB_ACK_RST    = 6'h3f;
  localparam int          LPB_RESP_RSV   = 2;

  typedef struct packed {
    logic [63:0] data;
    logic [7:0]  keep;
    logic        last;
    logic [7:0]  user;
  } lpb_beat_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } lpb_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } lpb_apb_rsp_t;

  typedef struct packed {
    logic       masterEnable;
    logic       rewind;
    logic [5:0] lastAck;
    logic [5:0] nextIdx;
  } lpb_phy_stat_t;

  typedef enum logic [1:0] {RD_IDLE, RD_FETCH, RD_SHOW} lpb_rd_t;

endpackage

// ==== lpb_mem.sv ====
// Simple dual-port beat memory with a registered read port.
// Assumes one clock; write and read may target any address each cycle.
`timescale 1ns/1ps
module lpb_mem #(
  parameter int WIDTH = 72,
  parameter int DEPTH = 288
) (
  input  wire logic                     core_clk,
  input  wire logic                     wrEn,
  input  wire logic [$clog2(DEPTH)-1:0] wrAddr,
  input  wire logic [WIDTH-1:0]         wrData,
  input  wire logic [$clog2(DEPTH)-1:0] rdAddr,
  output logic      [WIDTH-1:0]         rdData
);
  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge core_clk) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
    rdData <= mem[rdAddr];
  end
endmodule

// ==== lpb_apb.sv ====
// APB slave for the buffer configuration space.
// Assumes APB masters that hold a request until pready; answers in the first access cycle.
`timescale 1ns/1ps
module lpb_apb
  import lpb_pkg::*;
(
  input  wire logic         core_clk,
  input  wire logic         rst,
  input  wire lpb_apb_req_t apbReq,
  input  wire logic [31:0]  statusWord,
  input  wire logic [31:0]  dropCount,
  output lpb_apb_rsp_t      apbRsp,
  output logic [1:0]        ctrlBits
);
  typedef struct packed {
    lpb_apb_rsp_t rsp;
    logic [1:0]   ctrl;
  } lpb_apb_st_t;

  lpb_apb_st_t q;
  lpb_apb_st_t nxt;

  always_comb begin
    nxt = q;
    nxt.rsp.pready = 1'b0;
    if (apbReq.psel && !apbReq.penable) begin
      nxt.rsp.pready  = 1'b1;
      nxt.rsp.pslverr = 1'b0;
      nxt.rsp.prdata  = 32'h0;
      unique case (apbReq.paddr)
        LPB_REG_CTRL:   nxt.rsp.prdata = {30'h0, q.ctrl};
        LPB_REG_STATUS: nxt.rsp.prdata = statusWord;
        LPB_REG_DROPS:  nxt.rsp.prdata = dropCount;
        default:        nxt.rsp.pslverr = 1'b1;
      endcase
    end
    // Writes land on the edge where the master sees pready; read-only words ignore them.
    if (apbReq.psel && apbReq.penable && q.rsp.pready && apbReq.pwrite &&
        apbReq.paddr == LPB_REG_CTRL) begin
      nxt.ctrl = apbReq.pwdata[1:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      q <= '{rsp: '0, ctrl: LPB_CTRL_RST};
    end else begin
      q <= nxt;
    end
  end

  assign apbRsp   = q.rsp;
  assign ctrlBits = q.ctrl;
endmodule

// ==== link_packet_buffer.sv ====
// Transmit and receive packet buffer between the logical layer and the physical layer.
// Assumes one clock for both sides and 64-bit packet streams with valid/ready handshakes.
//
// Function
// - Tx and rx depths 8, 16 or 32.
// - Tx stores whole packet before forwarding.
// - Hold sent packet until partner acknowledges.
// - Queued responses go before queued requests.
// - Domain crossing stage selectable at build.
// - Crossing advised for multi-lane links.
// - Rx buffer forwards packets in order.
// - Rx path has no crossing stage; CDC_EN only re-times phyStat.
// - Keep all ones except last beat.
// - Delivered first beat: start and critical flag.
// - Undefined and later-beat sideband bits ignored.
// - Responses-only indication limits new requests.
// - 64-bit beats move on valid and ready.
// - Last marker only on final beat.
// - Two stream channels per side.
// - Register slave port for configuration.
// - Discontinued received packet is dropped whole.
// - Master enable low: only responses sent.
// - Free slots up to last acknowledge.
// - Rewind resumes from named packet index.
`timescale 1ns/1ps
module link_packet_buffer
  import lpb_pkg::*;
#(
  parameter int TX_DEPTH = 8,
  parameter int RX_DEPTH = 8,
  parameter int MAX_BEAT = LPB_MAX_BEAT,
  parameter bit CDC_EN   = 1'b0
) (
  input  wire logic          core_clk,
  input  wire logic          rst,
  input  wire logic          logTxValid,
  output logic               logTxReady,
  input  wire lpb_beat_t     logTxBeat,
  output logic               logRxValid,
  input  wire logic          logRxReady,
  output lpb_beat_t          logRxBeat,
  output logic               phyTxValid,
  input  wire logic          phyTxReady,
  output lpb_beat_t          phyTxBeat,
  input  wire logic          phyRxValid,
  output logic               phyRxReady,
  input  wire lpb_beat_t     phyRxBeat,
  output logic               responseOnly,
  input  wire lpb_phy_stat_t phyStat,
  input  wire lpb_apb_req_t  apbReq,
  output lpb_apb_rsp_t       apbRsp
);
  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int SW    = $clog2(TX_DEPTH);
  localparam int TXMEM = TX_DEPTH * MAX_BEAT;
  localparam int TAW   = $clog2(TXMEM);
  localparam int RAW   = $clog2(RX_DEPTH * MAX_BEAT);
  localparam int RXMEM = 2 ** RAW;
  localparam int PW    = $clog2(RX_DEPTH + 1);

  typedef struct packed {
    logic [TX_DEPTH-1:0]       used;
    logic [TX_DEPTH-1:0]       full;
    logic [TX_DEPTH-1:0]       sent;
    logic [TX_DEPTH-1:0]       resp;
    logic [TX_DEPTH-1:0]       crf;
    logic [TX_DEPTH-1:0][5:0]  ack;
    logic [TX_DEPTH-1:0][5:0]  len;
    logic                      inPkt;
    logic [SW-1:0]             wrSlot;
    logic [5:0]                wrBeat;
    lpb_rd_t                   txRd;
    logic [SW-1:0]             rdSlot;
    logic [5:0]                rdBeat;
    logic [5:0]                ackSeen;
    logic [RAW:0]              rxWr;
    logic [RAW:0]              rxCommit;
    logic [RAW:0]              rxRd;
    logic [PW-1:0]             rxPkts;
    logic                      rxFirstIn;
    lpb_rd_t                   rxRdSt;
    logic                      rxFirstOut;
    logic [31:0]               drops;
    lpb_phy_stat_t             sync1;
    lpb_phy_stat_t             sync2;
    logic                      logTxReady;
    logic                      logRxValid;
    lpb_beat_t                 logRxBeat;
    logic                      phyTxValid;
    lpb_beat_t                 phyTxBeat;
    logic                      phyRxReady;
    logic                      responseOnly;
  } lpb_st_t;

  lpb_st_t            q;
  lpb_st_t            nxt;
  lpb_phy_stat_t      stat;
  logic [1:0]         ctrlBits;
  logic [71:0]        txRdData;
  logic [73:0]        rxRdData;
  logic [TAW-1:0]     txWrAddr;
  logic [TAW-1:0]     txRdAddr;
  logic               txWrEn;
  logic               rxWrEn;
  logic [5:0]         usedCnt;
  logic [5:0]         freeCnt;
  logic [TX_DEPTH-1:0] respCand;
  logic [TX_DEPTH-1:0] reqCand;
  logic               pickHit;
  logic [SW-1:0]      pickSlot;
  logic               freeHit;
  logic [SW-1:0]      freeSlot;
  logic [5:0]         ackSpan;
  logic               txTake;
  logic               rxTake;

  // The optional stage re-times the physical-layer status; without it the two
  // sides must already share the clock, which the single-clock build assumes.
  assign stat = CDC_EN ? q.sync2 : phyStat;

  assign txTake   = logTxValid && q.logTxReady;
  assign rxTake   = phyRxValid && q.phyRxReady;
  assign txWrEn   = txTake;
  assign rxWrEn   = rxTake;
  assign txWrAddr = TAW'(nxt.wrSlot * MAX_BEAT + q.wrBeat);
  assign txRdAddr = TAW'(nxt.rdSlot * MAX_BEAT + nxt.rdBeat);

  always_comb begin
    nxt      = q;
    respCand = q.full & ~q.sent & q.resp;
    reqCand  = q.full & ~q.sent & ~q.resp & {TX_DEPTH{stat.masterEnable}};
    pickHit  = 1'b0;
    pickSlot = '0;
    freeHit  = 1'b0;
    freeSlot = '0;
    usedCnt  = '0;
    ackSpan  = stat.lastAck - 6'(q.ackSeen + 6'h1);
    // Lowest index wins; a pending response always beats a pending request.
    for (int i = TX_DEPTH - 1; i >= 0; i--) begin
      if (reqCand[i]) begin
        pickHit  = 1'b1;
        pickSlot = SW'(i);
      end
      if (!q.used[i]) begin
        freeHit  = 1'b1;
        freeSlot = SW'(i);
      end
    end
    for (int i = TX_DEPTH - 1; i >= 0; i--) begin
      if (respCand[i]) begin
        pickHit  = 1'b1;
        pickSlot = SW'(i);
      end
    end

    nxt.sync1 = phyStat;
    nxt.sync2 = q.sync1;

    // Transmit fill: a slot is claimed on the first beat and only offered
    // for sending once its last beat has been stored.
    if (txTake) begin
      if (!q.inPkt) begin
        nxt.wrSlot               = freeSlot;
        nxt.used[freeSlot]       = 1'b1;
        nxt.resp[freeSlot]       = logTxBeat.user[LPB_TU_RESP];
        nxt.crf[freeSlot]        = logTxBeat.user[LPB_TU_CRF];
      end
      nxt.inPkt  = !logTxBeat.last;
      nxt.wrBeat = logTxBeat.last ? 6'h0 : 6'(q.wrBeat + 6'h1);
      if (logTxBeat.last) begin
        nxt.full[nxt.wrSlot] = 1'b1;
        nxt.len[nxt.wrSlot]  = q.wrBeat;
      end
    end

    // Acknowledge: free every sent slot whose index lies in the window that
    // the acknowledge pointer just moved across.
    if (stat.lastAck != q.ackSeen) begin
      for (int i = 0; i < TX_DEPTH; i++) begin
        if (q.sent[i] && 6'(q.ack[i] - 6'(q.ackSeen + 6'h1)) <= ackSpan) begin
          nxt.used[i] = 1'b0;
          nxt.full[i] = 1'b0;
          nxt.sent[i] = 1'b0;
        end
      end
      nxt.ackSeen = stat.lastAck;
    end
    if (stat.rewind) begin
      // Unacknowledged packets go back in the queue and take fresh indices
      // from the next-packet input as they are sent again.
      nxt.sent = '0;
    end

    // Transmit drain.
    unique case (q.txRd)
      RD_IDLE: begin
        if (pickHit && !ctrlBits[LPB_CTRL_PAUSE]) begin
          nxt.rdSlot = pickSlot;
          nxt.rdBeat = 6'h0;
          nxt.txRd   = RD_FETCH;
        end
      end
      RD_FETCH: begin
        nxt.phyTxValid     = 1'b1;
        nxt.phyTxBeat.data = txRdData[63:0];
        nxt.phyTxBeat.keep = txRdData[71:64];
        nxt.phyTxBeat.last = q.rdBeat == q.len[q.rdSlot];
        nxt.phyTxBeat.user = 8'h0;
        if (q.rdBeat == 6'h0) begin
          nxt.phyTxBeat.user[LPB_TU_CRF] = q.crf[q.rdSlot] & ctrlBits[LPB_CTRL_CRF];
          nxt.ack[q.rdSlot]              = stat.nextIdx;
        end
        nxt.txRd = RD_SHOW;
      end
      RD_SHOW: begin
        if (phyTxReady) begin
          nxt.phyTxValid = 1'b0;
          if (q.phyTxBeat.last) begin
            if (!stat.rewind) begin
              nxt.sent[q.rdSlot] = 1'b1;
            end
            nxt.txRd = RD_IDLE;
          end else begin
            nxt.rdBeat = 6'(q.rdBeat + 6'h1);
            nxt.txRd   = RD_FETCH;
          end
        end
      end
    endcase

    for (int i = 0; i < TX_DEPTH; i++) begin
      usedCnt = usedCnt + 6'(nxt.used[i]);
    end
    freeCnt            = 6'(TX_DEPTH) - usedCnt;
    nxt.responseOnly   = freeCnt <= 6'(LPB_RESP_RSV);
    nxt.logTxReady     = nxt.inPkt ? (nxt.wrBeat < 6'(MAX_BEAT)) : (freeCnt != 6'h0);

    // Receive fill with whole-packet discard on a discontinued last beat.
    if (rxTake) begin
      nxt.rxFirstIn = phyRxBeat.last;
      if (phyRxBeat.last && phyRxBeat.user[LPB_TU_DISC]) begin
        nxt.rxWr  = q.rxCommit;
        nxt.drops = q.drops + 32'h1;
      end else begin
        nxt.rxWr = (RAW + 1)'(q.rxWr + 1'b1);
        if (phyRxBeat.last) begin
          nxt.rxCommit = nxt.rxWr;
          nxt.rxPkts   = PW'(nxt.rxPkts + 1'b1);
        end
      end
    end

    // Receive drain, strictly in arrival order.
    unique case (q.rxRdSt)
      RD_IDLE: begin
        if (q.rxRd != q.rxCommit) begin
          nxt.rxRdSt = RD_FETCH;
        end
      end
      RD_FETCH: begin
        nxt.logRxValid     = 1'b1;
        nxt.logRxBeat.data = rxRdData[63:0];
        nxt.logRxBeat.keep = rxRdData[71:64];
        nxt.logRxBeat.last = rxRdData[72];
        nxt.logRxBeat.user = 8'h0;
        if (q.rxFirstOut) begin
          nxt.logRxBeat.user[LPB_TU_SOP] = 1'b1;
          nxt.logRxBeat.user[LPB_TU_CRF] = rxRdData[73] & ctrlBits[LPB_CTRL_CRF];
        end
        nxt.rxRd   = (RAW + 1)'(q.rxRd + 1'b1);
        nxt.rxRdSt = RD_SHOW;
      end
      RD_SHOW: begin
        if (logRxReady) begin
          nxt.logRxValid = 1'b0;
          nxt.rxFirstOut = q.logRxBeat.last;
          if (q.logRxBeat.last) begin
            nxt.rxPkts = PW'(nxt.rxPkts - 1'b1);
          end
          nxt.rxRdSt = RD_IDLE;
        end
      end
    endcase
    nxt.phyRxReady = ((RAW + 1)'(nxt.rxWr - nxt.rxRd) < (RAW + 1)'(RXMEM - 1)) &&
                     (nxt.rxPkts < PW'(RX_DEPTH));
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      q            <= '0;
      q.ackSeen    <= LPB_ACK_RST;
      q.rxFirstIn  <= 1'b1;
      q.rxFirstOut <= 1'b1;
      q.txRd       <= RD_IDLE;
      q.rxRdSt     <= RD_IDLE;
    end else begin
      q <= nxt;
    end
  end

  // ----------------------------------------------------------------
  // Storage and configuration
  // ----------------------------------------------------------------
  lpb_mem #(.WIDTH(72), .DEPTH(TXMEM)) txMem (
    .core_clk (core_clk),
    .wrEn     (txWrEn),
    .wrAddr   (txWrAddr),
    .wrData   ({logTxBeat.keep, logTxBeat.data}),
    .rdAddr   (txRdAddr),
    .rdData   (txRdData)
  );

  // Bit 73 keeps the critical-flow flag seen on the packet's first beat.
  lpb_mem #(.WIDTH(74), .DEPTH(RXMEM)) rxMem (
    .core_clk (core_clk),
    .wrEn     (rxWrEn),
    .wrAddr   (q.rxWr[RAW-1:0]),
    .wrData   ({phyRxBeat.user[LPB_TU_CRF] & q.rxFirstIn, phyRxBeat.last,
                phyRxBeat.keep, phyRxBeat.data}),
    .rdAddr   (nxt.rxRd[RAW-1:0]),
    .rdData   (rxRdData)
  );

  lpb_apb regs (
    .core_clk   (core_clk),
    .rst        (rst),
    .apbReq     (apbReq),
    .statusWord ({14'h0, stat.masterEnable, q.responseOnly,
                  8'(q.rxPkts), 2'h0, usedCnt}),
    .dropCount  (q.drops),
    .apbRsp     (apbRsp),
    .ctrlBits   (ctrlBits)
  );

  // Two channels face each side.
  assign logTxReady   = q.logTxReady;
  assign logRxValid   = q.logRxValid;
  assign logRxBeat    = q.logRxBeat;
  assign phyTxValid   = q.phyTxValid;
  assign phyTxBeat    = q.phyTxBeat;
  assign phyRxReady   = q.phyRxReady;
  assign responseOnly = q.responseOnly;
endmodule

// ==== lpb_assertions.sv ====
// Port checks for the link packet buffer.
// Assumes the single core clock and its synchronous active-high reset.
`timescale 1ns/1ps
module lpb_assertions
  import lpb_pkg::*;
(
  input wire logic         core_clk,
  input wire logic         rst,
  input wire logic         logRxValid,
  input wire logic         logRxReady,
  input wire lpb_beat_t    logRxBeat,
  input wire logic         phyTxValid,
  input wire logic         phyTxReady,
  input wire lpb_beat_t    phyTxBeat,
  input wire lpb_apb_req_t apbReq,
  input wire lpb_apb_rsp_t apbRsp
);
  // Tracks whether the next delivered beat is inside a packet.
  logic rxMid_ff;
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rxMid_ff <= 1'b0;
    end else if (logRxValid && logRxReady) begin
      rxMid_ff <= !logRxBeat.last;
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  property p_rxKeep;
    logRxValid && !logRxBeat.last |-> logRxBeat.keep == LPB_KEEP_ALL;
  endproperty
  a_rxKeep: assert property (p_rxKeep) else $error("rx keep not full");
  property p_txKeep;
    phyTxValid && !phyTxBeat.last |-> phyTxBeat.keep == LPB_KEEP_ALL;
  endproperty
  a_txKeep: assert property (p_txKeep) else $error("tx keep not full");
  property p_rxHold;
    logRxValid && !logRxReady |=> logRxValid && $stable(logRxBeat);
  endproperty
  a_rxHold: assert property (p_rxHold) else $error("rx beat dropped");
  property p_txHold;
    phyTxValid && !phyTxReady |=> phyTxValid && $stable(phyTxBeat);
  endproperty
  a_txHold: assert property (p_txHold) else $error("tx beat dropped");
  property p_rxSop;
    logRxValid && !rxMid_ff |-> logRxBeat.user[LPB_TU_SOP];
  endproperty
  a_rxSop: assert property (p_rxSop) else $error("start mark missing");
  property p_rxLater;
    logRxValid && rxMid_ff |-> logRxBeat.user == 8'h00;
  endproperty
  a_rxLater: assert property (p_rxLater) else $error("later sideband set");
  property p_apbReady;
    apbReq.psel && !apbReq.penable |=> apbRsp.pready ##1 !apbRsp.pready;
  endproperty
  a_apbReady: assert property (p_apbReady) else $error("bad ready");
  property p_apbErr;
    apbReq.psel && !apbReq.penable && apbReq.paddr > LPB_REG_DROPS
      |=> apbRsp.pslverr && apbRsp.prdata == 32'h0;
  endproperty
  a_apbErr: assert property (p_apbErr) else $error("unmapped accepted");
  property p_quiet;
    $fell(rst) |-> !logRxValid && !phyTxValid && !apbRsp.pready;
  endproperty
  a_quiet: assert property (p_quiet) else $error("active after reset");
  c_rxEnd: cover property (logRxValid && logRxReady && logRxBeat.last);
  c_txStall: cover property (phyTxValid && !phyTxReady);
  c_apbErr: cover property (apbRsp.pslverr);
endmodule
bind link_packet_buffer lpb_assertions u_chk (
  .core_clk(core_clk), .rst(rst), .logRxValid(logRxValid), .logRxReady(logRxReady),
  .logRxBeat(logRxBeat), .phyTxValid(phyTxValid), .phyTxReady(phyTxReady),
  .phyTxBeat(phyTxBeat), .apbReq(apbReq), .apbRsp(apbRsp));

// ==== lpb_phy_model.sv ====
// Physical-layer partner: takes transmitted packets and reports acknowledges.
// Assumes one clock; mode 0 ready, 1 ready every other cycle, 2 stalled.
`timescale 1ns/1ps
module lpb_phy_model
  import lpb_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic       phyTxValid,
  input  wire lpb_beat_t  phyTxBeat,
  input  wire logic [1:0] mode,
  input  wire logic       meEn,
  input  wire logic       ackEn,
  input  wire logic       rewEn,
  output logic            phyTxReady,
  output lpb_phy_stat_t   phyStat
);
  always_ff @(posedge core_clk) begin
    if (rst) begin
      phyTxReady <= 1'b0;
      phyStat    <= '{1'b0, 1'b0, LPB_ACK_RST, 6'h00};
    end else begin
      phyTxReady <= (mode == 2'h0) || (mode == 2'h1 && !phyTxReady);
      phyStat.masterEnable <= meEn;
      phyStat.rewind       <= rewEn;
      // A rewind names the oldest unacknowledged packet as the next one to send.
      if (rewEn) begin
        phyStat.nextIdx <= phyStat.lastAck + 6'h01;
      end else if (phyTxValid && phyTxReady && phyTxBeat.last) begin
        phyStat.nextIdx <= phyStat.nextIdx + 6'h01;
      end
      // Acknowledging everything sent lets the index jump by several.
      if (ackEn) begin
        phyStat.lastAck <= phyStat.nextIdx - 6'h01;
      end
    end
  end
endmodule

// ==== test_link_packet_buffer.sv ====
// Self-checking bench for the link packet buffer.
// Assumes the partner model on the physical transmit side.
`timescale 1ns/1ps
module test_link_packet_buffer;
  import lpb_pkg::*;
  logic          core_clk = 1'b0, rst = 1'b1, txMid = 1'b0;
  logic          logTxValid = 1'b0, logRxReady = 1'b1, phyRxValid = 1'b0;
  logic          logTxReady, logRxValid, phyTxValid, phyTxReady, phyRxReady, responseOnly;
  logic          meEn = 1'b1, ackEn = 1'b0, rewEn = 1'b0;
  logic [1:0]    mode = 2'h0;
  lpb_beat_t     logTxBeat = '0, phyRxBeat = '0, logRxBeat, phyTxBeat;
  lpb_phy_stat_t phyStat;
  lpb_apb_req_t  apbReq = '0;
  lpb_apb_rsp_t  apbRsp;
  logic [80:0]   r;
  lpb_beat_t     rxQ[$], txQ[$];
  int            n_mismatch = 0, num_checks = 0;
  always #10 core_clk = ~core_clk;
  link_packet_buffer #(.TX_DEPTH(8), .RX_DEPTH(8)) dut (.core_clk(core_clk), .rst(rst),
    .logTxValid(logTxValid), .logTxReady(logTxReady), .logTxBeat(logTxBeat),
    .logRxValid(logRxValid), .logRxReady(logRxReady), .logRxBeat(logRxBeat),
    .phyTxValid(phyTxValid), .phyTxReady(phyTxReady), .phyTxBeat(phyTxBeat),
    .phyRxValid(phyRxValid), .phyRxReady(phyRxReady), .phyRxBeat(phyRxBeat),
    .responseOnly(responseOnly), .phyStat(phyStat), .apbReq(apbReq), .apbRsp(apbRsp));
  lpb_phy_model phy (.core_clk(core_clk), .rst(rst), .phyTxValid(phyTxValid),
    .phyTxBeat(phyTxBeat), .mode(mode), .meEn(meEn), .ackEn(ackEn), .rewEn(rewEn),
    .phyTxReady(phyTxReady), .phyStat(phyStat));
  always @(posedge core_clk) begin
    if (logRxValid && logRxReady) rxQ.push_back(logRxBeat);
    if (phyTxValid && phyTxReady) begin
      if (!txMid) txQ.push_back(phyTxBeat);
      txMid = !phyTxBeat.last;
    end
  end
  task automatic check(input logic [80:0] got, input logic [80:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish();
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // Every task is entered and left just after a rising edge.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    apbReq <= '{1'b1, 1'b0, wr, a, d};
    @(posedge core_clk) apbReq.penable <= 1'b1;
    do @(posedge core_clk); while (apbRsp.pready !== 1'b1);
    r = 81'({apbRsp.pslverr, apbRsp.prdata});
    apbReq <= '0;
    @(posedge core_clk);
  endtask
  function automatic lpb_beat_t mk(logic [63:0] d, logic [7:0] u, logic [7:0] z, int n, int i);
    mk = '{d + 64'(i), (i == n - 1) ? 8'h0f : LPB_KEEP_ALL, i == n - 1,
           (i == 0 ? u : 8'h00) | (i == n - 1 ? z : 8'h00)};
  endfunction
  task automatic send(input bit rx, input logic [63:0] d, input logic [7:0] u,
                      input logic [7:0] z, input int n);
    for (int i = 0; i < n; i++) begin
      if (rx) begin
        phyRxValid <= 1'b1;
        phyRxBeat  <= mk(d, u, z, n, i);
      end else begin
        logTxValid <= 1'b1;
        logTxBeat  <= mk(d, u, z, n, i);
      end
      do @(posedge core_clk); while ((rx ? phyRxReady : logTxReady) !== 1'b1);
    end
    phyRxValid <= 1'b0;
    logTxValid <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic expRx(input logic [63:0] d, input logic [7:0] u, input int n);
    while (rxQ.size() < n) @(posedge core_clk);
    for (int i = 0; i < n; i++) check(rxQ.pop_front(), mk(d, 8'h08 | u, 8'h00, n, i));
  endtask
  task automatic waitTx(input int n);
    while (txQ.size() < n) @(posedge core_clk);
  endtask
  initial begin
    repeat (10) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    apb(0, LPB_REG_CTRL, 0);
    check(r, 81'(LPB_CTRL_RST));
    apb(1, LPB_REG_STATUS, 32'hffffffff);
    apb(0, LPB_REG_STATUS, 0);
    check(r, 81'h20000);
    apb(0, 12'h00c, 0);
    check(r, 81'h100000000);
    // A stalled partner lets a response overtake a queued request.
    mode <= 2'h2;
    send(0, 64'h100, 8'h00, 8'h00, 2);
    send(0, 64'h200, 8'h00, 8'h00, 3);
    send(0, 64'h300, 8'h10, 8'h00, 2);
    mode <= 2'h1;
    waitTx(3);
    check(81'(txQ[1].data), 81'h300);
    check(81'(txQ[2].data), 81'h200);
    meEn <= 1'b0;
    send(0, 64'h400, 8'h00, 8'h00, 1);
    send(0, 64'h500, 8'h10, 8'h00, 1);
    waitTx(4);
    repeat (20) @(posedge core_clk);
    check(81'(txQ.size()), 81'h4);
    meEn <= 1'b1;
    waitTx(5);
    check(81'(txQ[4].data), 81'h400);
    apb(0, LPB_REG_STATUS, 0);
    check(r, 81'h20005);
    for (int k = 0; k < 3; k++) send(0, 64'h600, 8'h10, 8'h00, 1);
    waitTx(8);
    repeat (4) @(posedge core_clk);
    check(81'({logTxReady, responseOnly}), 81'h1);
    ackEn <= 1'b1;
    while (logTxReady !== 1'b1) @(posedge core_clk);
    apb(0, LPB_REG_STATUS, 0);
    check(r, 81'h20000);
    check(81'(responseOnly), 81'h0);
    // Pause holds a queued packet back; a rewind sends an unacknowledged one again.
    ackEn <= 1'b0;
    apb(1, LPB_REG_CTRL, 32'h3);
    send(0, 64'hb00, 8'h02, 8'h00, 1);
    repeat (20) @(posedge core_clk);
    check(81'(txQ.size()), 81'h8);
    apb(1, LPB_REG_CTRL, 32'h1);
    waitTx(9);
    check(txQ[8], {64'hb00, 8'h0f, 1'b1, 8'h02});
    rewEn <= 1'b1;
    @(posedge core_clk);
    rewEn <= 1'b0;
    waitTx(10);
    check(81'(txQ[9].data), 81'hb00);
    ackEn <= 1'b1;
    repeat (4) @(posedge core_clk);
    apb(0, LPB_REG_STATUS, 0);
    check(r, 81'h20000);
    // Receive path with the reader stalled, a discarded packet and critical flow off.
    logRxReady <= 1'b0;
    send(1, 64'h700, 8'h02, 8'h00, 3);
    send(1, 64'h800, 8'h00, 8'h01, 2);
    send(1, 64'h900, 8'h00, 8'h00, 1);
    logRxReady <= 1'b1;
    expRx(64'h700, 8'h02, 3);
    expRx(64'h900, 8'h00, 1);
    apb(0, LPB_REG_DROPS, 0);
    check(r, 81'h1);
    apb(1, LPB_REG_CTRL, 0);
    send(1, 64'ha00, 8'h02, 8'h00, 2);
    expRx(64'ha00, 8'h00, 2);
    tally_and_finish();
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    n_mismatch++;
    tally_and_finish();
  end
endmodule
